/* File: rtl/rfsc_top.v */
// Lead-signal generator for an external RF front-end, with pin routing,
// edge/level detector, sticky interrupt status and an Avalon-MM slave.
// Assumes the radio sequencer delivers one-cycle request and end pulses
// synchronous to i_core_clk.
//
// Contract
// [RQ1] Transmit lead rises early, falls after amplifier off.
// [RQ2] Receive lead rises early, falls on receive exit.
// [RQ3] Transmit lead 118 or 58 us early.
// [RQ4] Receive lead 116 or 56 us early.
// [RQ5] Channel change calibrates and selects longer lead.
// [RQ6] Automatic mode routes leads via pin functions.
// [RQ7] Automatic mode pins need no firmware action.
// [RQ8] Pin encoding: sleep, receive, transmit exclusive.
// [RQ9] Detector raises interrupt per lead signal.
// [RQ10] Per lead trigger, edge/level type, enable.
// [RQ11] Firmware drives pins in interrupt mode.
// [RQ12] Lead interrupt priority below completion interrupt.
// [RQ13] Completion interrupt only at sequence end.
`timescale 1ns/100ps
`include "rfsc_defines.vh"

module rfsc_top #(
    parameter CH_W          = `RFSC_CH_W,
    parameter TX_CAL_CYC    = `RFSC_TX_LEAD_CAL_US * `RFSC_CLK_MHZ,
    parameter TX_NOCAL_CYC  = `RFSC_TX_LEAD_NOCAL_US * `RFSC_CLK_MHZ,
    parameter RX_CAL_CYC    = `RFSC_RX_LEAD_CAL_US * `RFSC_CLK_MHZ,
    parameter RX_NOCAL_CYC  = `RFSC_RX_LEAD_NOCAL_US * `RFSC_CLK_MHZ
) (
    input  wire             i_core_clk,
    input  wire             i_srst,
    input  wire [7:0]       i_avs_address,
    input  wire             i_avs_read,
    input  wire             i_avs_write,
    input  wire [31:0]      i_avs_writedata,
    output reg  [31:0]      o_avs_readdata,
    output reg              o_avs_waitrequest,
    input  wire             i_tx_req,
    input  wire             i_rx_req,
    input  wire [CH_W-1:0]  i_channel,
    input  wire             i_pa_off,
    input  wire             i_rx_exit,
    output reg              o_tx_lead,
    output reg              o_rx_lead,
    output reg              o_tx_air,
    output reg              o_rx_air,
    output reg              o_pll_cal,
    output reg              o_tx_ctrl_pin_a,
    output reg              o_tx_ctrl_pin_b,
    output reg              o_rx_ctrl_pin_a,
    output reg              o_rx_ctrl_pin_b,
    output reg              o_lead_irq,
    output reg              o_done_irq
);

    localparam [4:0] ST_IDLE    = 5'h01;
    localparam [4:0] ST_TX_LEAD = 5'h02;
    localparam [4:0] ST_TX_AIR  = 5'h04;
    localparam [4:0] ST_RX_LEAD = 5'h08;
    localparam [4:0] ST_RX_AIR  = 5'h10;
    localparam CW = `RFSC_CNT_W;

    // Reload values are one short because the lead ends on the edge that
    // sees the counter at zero.
    localparam [31:0] TX_CAL_LOAD   = TX_CAL_CYC - 1;
    localparam [31:0] TX_NOCAL_LOAD = TX_NOCAL_CYC - 1;
    localparam [31:0] RX_CAL_LOAD   = RX_CAL_CYC - 1;
    localparam [31:0] RX_NOCAL_LOAD = RX_NOCAL_CYC - 1;

    ////////////////////////////////////////////////////////////////////////
    // Detector helper: one lead signal against its trigger configuration.

    function det_hit;
        input       cur;
        input       prev;
        input [2:0] cfg;
        begin
            if (cfg[`RFSC_TYPE_LEVEL_BIT]) begin
                det_hit = (cfg[`RFSC_TRIG_RISE_BIT] & cur) |
                          (cfg[`RFSC_TRIG_FALL_BIT] & ~cur);
            end else begin
                det_hit = (cfg[`RFSC_TRIG_RISE_BIT] & cur & ~prev) |
                          (cfg[`RFSC_TRIG_FALL_BIT] & ~cur & prev);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin helper: a wrong function code leaves the pin with firmware, so a
    // half-configured board never sees a lead it did not ask for.

    function pin_level;
        input       auto_on;
        input [1:0] code;
        input [1:0] want;
        input       lead;
        input       fw;
        begin
            if (auto_on && code == want) begin
                pin_level = lead;
            end else begin
                pin_level = fw;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    reg [4:0]      state_reg;
    reg [CW-1:0]   cnt_reg;
    reg [CH_W-1:0] last_ch_reg;
    reg            ch_valid_reg;
    reg            done_pulse_reg;
    wire           cal_need = ~ch_valid_reg | (i_channel != last_ch_reg); // [RQ5]

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            state_reg      <= ST_IDLE;
            cnt_reg        <= {CW{1'b0}};
            last_ch_reg    <= {CH_W{1'b0}};
            ch_valid_reg   <= 1'b0;
            done_pulse_reg <= 1'b0;
            o_tx_lead      <= 1'b0;
            o_rx_lead      <= 1'b0;
            o_tx_air       <= 1'b0;
            o_rx_air       <= 1'b0;
            o_pll_cal      <= 1'b0;
        end else begin
            done_pulse_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    // A simultaneous receive request loses to transmit.
                    if (i_tx_req || i_rx_req) begin
                        last_ch_reg  <= i_channel;
                        ch_valid_reg <= 1'b1;
                        o_pll_cal    <= cal_need; // [RQ5]
                    end
                    if (i_tx_req) begin
                        state_reg <= ST_TX_LEAD;
                        o_tx_lead <= 1'b1; // [RQ1]
                        cnt_reg   <= cal_need ? TX_CAL_LOAD[CW-1:0] :
                                                TX_NOCAL_LOAD[CW-1:0]; // [RQ3]
                    end else if (i_rx_req) begin
                        state_reg <= ST_RX_LEAD;
                        o_rx_lead <= 1'b1; // [RQ2]
                        cnt_reg   <= cal_need ? RX_CAL_LOAD[CW-1:0] :
                                                RX_NOCAL_LOAD[CW-1:0]; // [RQ4]
                    end
                end
                ST_TX_LEAD: begin
                    if (cnt_reg == {CW{1'b0}}) begin
                        state_reg <= ST_TX_AIR; // [RQ3]
                        o_tx_air  <= 1'b1;
                        o_pll_cal <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_TX_AIR: begin
                    if (i_pa_off) begin
                        state_reg      <= ST_IDLE;
                        o_tx_air       <= 1'b0;
                        o_tx_lead      <= 1'b0; // [RQ1]
                        done_pulse_reg <= 1'b1; // [RQ13]
                    end
                end
                ST_RX_LEAD: begin
                    if (cnt_reg == {CW{1'b0}}) begin
                        state_reg <= ST_RX_AIR; // [RQ4]
                        o_rx_air  <= 1'b1;
                        o_pll_cal <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                ST_RX_AIR: begin
                    if (i_rx_exit) begin
                        state_reg      <= ST_IDLE;
                        o_rx_air       <= 1'b0;
                        o_rx_lead      <= 1'b0; // [RQ2]
                        done_pulse_reg <= 1'b1; // [RQ13]
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and Avalon-MM slave.

    reg        auto_mode_reg;
    reg [7:0]  pin_af_reg;
    reg [3:0]  gpio_out_reg;
    reg [7:0]  det_cfg_reg;
    reg [2:0]  irq_status_reg;
    reg [2:0]  irq_mask_reg;
    reg        tx_prev_reg;
    reg        rx_prev_reg;
    reg [31:0] rd_next;
    reg [2:0]  irq_status_next;

    // The answer is always one wait cycle: the request stalls for exactly one
    // edge, which keeps read data registered without a mux on the bus.
    wire req     = i_avs_read | i_avs_write;
    wire wr_take = i_avs_write & ~o_avs_waitrequest;
    wire tx_hit  = det_hit(o_tx_lead, tx_prev_reg, det_cfg_reg[2:0]); // [RQ9] [RQ10]
    wire rx_hit  = det_hit(o_rx_lead, rx_prev_reg,
                           det_cfg_reg[`RFSC_RX_CFG_POS +: 3]); // [RQ9] [RQ10]

    always @* begin
        rd_next = 32'h0;
        case (i_avs_address)
            `RFSC_ADDR_CTRL:       rd_next[0]   = auto_mode_reg;
            `RFSC_ADDR_PIN_AF:     rd_next[7:0] = pin_af_reg;
            `RFSC_ADDR_GPIO_OUT:   rd_next[3:0] = gpio_out_reg;
            `RFSC_ADDR_DET_CFG:    rd_next[7:0] = det_cfg_reg;
            `RFSC_ADDR_IRQ_STATUS: rd_next[2:0] = irq_status_reg;
            `RFSC_ADDR_IRQ_MASK:   rd_next[2:0] = irq_mask_reg;
            `RFSC_ADDR_STATE:      rd_next[4:0] = {o_pll_cal, o_rx_air, o_tx_air,
                                                   o_rx_lead, o_tx_lead};
            default:               rd_next = 32'h0;
        endcase
    end

    always @* begin
        irq_status_next = irq_status_reg;
        if (wr_take && i_avs_address == `RFSC_ADDR_IRQ_STATUS) begin
            irq_status_next = irq_status_next & ~i_avs_writedata[2:0];
        end
        // Set after clear, so an event in the clearing cycle survives.
        if (tx_hit) begin
            irq_status_next[`RFSC_ST_TX_BIT] = 1'b1; // [RQ9]
        end
        if (rx_hit) begin
            irq_status_next[`RFSC_ST_RX_BIT] = 1'b1; // [RQ9]
        end
        if (done_pulse_reg) begin
            irq_status_next[`RFSC_ST_DONE_BIT] = 1'b1; // [RQ13]
        end
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_avs_readdata    <= 32'h0;
            o_avs_waitrequest <= 1'b1;
            auto_mode_reg     <= 1'b0;
            pin_af_reg        <= 8'h0;
            gpio_out_reg      <= 4'h0;
            det_cfg_reg       <= `RFSC_DET_CFG_RST;
            irq_status_reg    <= 3'h0;
            irq_mask_reg      <= 3'h0;
            tx_prev_reg       <= 1'b0;
            rx_prev_reg       <= 1'b0;
            o_lead_irq        <= 1'b0;
            o_done_irq        <= 1'b0;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                o_avs_readdata <= rd_next;
            end
            if (wr_take) begin
                case (i_avs_address)
                    `RFSC_ADDR_CTRL:      auto_mode_reg <= i_avs_writedata[0];
                    `RFSC_ADDR_PIN_AF:    pin_af_reg    <= i_avs_writedata[7:0];
                    `RFSC_ADDR_GPIO_OUT:  gpio_out_reg  <= i_avs_writedata[3:0];
                    `RFSC_ADDR_DET_CFG:   det_cfg_reg   <= i_avs_writedata[7:0];
                    `RFSC_ADDR_IRQ_MASK:  irq_mask_reg  <= i_avs_writedata[2:0];
                    default: begin
                    end
                endcase
            end
            tx_prev_reg    <= o_tx_lead;
            rx_prev_reg    <= o_rx_lead;
            irq_status_reg <= irq_status_next;
            // Separate lines let the interrupt controller rank completion above lead.
            o_lead_irq <= |(irq_status_next[1:0] & irq_mask_reg[1:0]); // [RQ10] [RQ12]
            o_done_irq <= irq_status_next[2] & irq_mask_reg[2]; // [RQ13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin routing: a pin follows its lead only in automatic mode with the
    // matching function code, otherwise it shows the firmware output bit.

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_tx_ctrl_pin_a <= 1'b0;
            o_tx_ctrl_pin_b <= 1'b0;
            o_rx_ctrl_pin_a <= 1'b0;
            o_rx_ctrl_pin_b <= 1'b0;
        end else begin
            o_tx_ctrl_pin_a <= pin_level(auto_mode_reg, pin_af_reg[1:0], `RFSC_AF_TWO,
                                         o_tx_lead, gpio_out_reg[0]); // [RQ6] [RQ7] [RQ8] [RQ11]
            o_tx_ctrl_pin_b <= pin_level(auto_mode_reg, pin_af_reg[3:2], `RFSC_AF_ONE,
                                         o_tx_lead, gpio_out_reg[1]); // [RQ6] [RQ7] [RQ8]
            o_rx_ctrl_pin_a <= pin_level(auto_mode_reg, pin_af_reg[5:4], `RFSC_AF_TWO,
                                         o_rx_lead, gpio_out_reg[2]); // [RQ6] [RQ7] [RQ8]
            o_rx_ctrl_pin_b <= pin_level(auto_mode_reg, pin_af_reg[7:6], `RFSC_AF_TWO,
                                         o_rx_lead, gpio_out_reg[3]); // [RQ6] [RQ7] [RQ8]
        end
    end

endmodule // rfsc_top

/* File: rtl/rfsc_defines.vh */
// Constants for the RF front-end lead-signal controller.
// Assumes a 50 MHz core clock and a 32-bit Avalon-MM register port.
`ifndef RFSC_DEFINES_VH
`define RFSC_DEFINES_VH

`define RFSC_CLK_MHZ          50
`define RFSC_TX_LEAD_CAL_US   118
`define RFSC_TX_LEAD_NOCAL_US 58
`define RFSC_RX_LEAD_CAL_US   116
`define RFSC_RX_LEAD_NOCAL_US 56
`define RFSC_CNT_W            16
`define RFSC_CH_W             7

`define RFSC_ADDR_CTRL        8'h00
`define RFSC_ADDR_PIN_AF      8'h04
`define RFSC_ADDR_GPIO_OUT    8'h08
`define RFSC_ADDR_DET_CFG     8'h0c
`define RFSC_ADDR_IRQ_STATUS  8'h10
`define RFSC_ADDR_IRQ_MASK    8'h14
`define RFSC_ADDR_STATE       8'h18

`define RFSC_AF_ONE           2'h1
`define RFSC_AF_TWO           2'h2
`define RFSC_TRIG_RISE_BIT    0
`define RFSC_TRIG_FALL_BIT    1
`define RFSC_TYPE_LEVEL_BIT   2
`define RFSC_RX_CFG_POS       4
`define RFSC_ST_TX_BIT        0
`define RFSC_ST_RX_BIT        1
`define RFSC_ST_DONE_BIT      2
`define RFSC_DET_CFG_RST      8'h33

`endif

/* File: sim/rfsc_sva.sv */
// Port checker for the lead-signal controller.
// Assumes it is bound to rfsc_top and receives the same lead parameters.
`timescale 1ns/100ps
module rfsc_sva #(
    parameter CH_W         = 7,
    parameter TX_CAL_CYC   = 8,
    parameter TX_NOCAL_CYC = 4,
    parameter RX_CAL_CYC   = 6,
    parameter RX_NOCAL_CYC = 3
) (
    input logic            i_core_clk,
    input logic            i_srst,
    input logic            i_tx_req,
    input logic            i_rx_req,
    input logic [CH_W-1:0] i_channel,
    input logic            i_pa_off,
    input logic            i_rx_exit,
    input logic            o_tx_lead,
    input logic            o_rx_lead,
    input logic            o_tx_air,
    input logic            o_rx_air,
    input logic            o_pll_cal,
    input logic            o_done_irq
);
    logic [CH_W-1:0] last_ch;
    logic            have;
    logic            cal_q;
    wire             idle = !o_tx_lead && !o_rx_lead;

    // Tracks whether the request just taken must calibrate.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            have <= 1'h0;
            cal_q <= 1'h0;
            last_ch <= '0;
        end else if ((i_tx_req || i_rx_req) && idle) begin
            have <= 1'h1;
            last_ch <= i_channel;
            cal_q <= !have || (i_channel != last_ch);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    tx_cal_lead_a: assert property ($rose(o_tx_lead) && o_pll_cal |->
        ##TX_CAL_CYC $rose(o_tx_air)) else $error("tx lead with calibration wrong");
    tx_nocal_lead_a: assert property ($rose(o_tx_lead) && !o_pll_cal |->
        ##TX_NOCAL_CYC $rose(o_tx_air)) else $error("tx lead without calibration wrong");
    rx_cal_lead_a: assert property ($rose(o_rx_lead) && o_pll_cal |->
        ##RX_CAL_CYC $rose(o_rx_air)) else $error("rx lead with calibration wrong");
    rx_nocal_lead_a: assert property ($rose(o_rx_lead) && !o_pll_cal |->
        ##RX_NOCAL_CYC $rose(o_rx_air)) else $error("rx lead without calibration wrong");
    cal_choice_a: assert property ($rose(o_tx_lead) || $rose(o_rx_lead) |->
        o_pll_cal == cal_q) else $error("calibration choice wrong");
    lead_excl_a: assert property (!(o_tx_lead && o_rx_lead))
        else $error("both leads high");
    tx_release_a: assert property ($fell(o_tx_lead) |->
        $past(i_pa_off) && $past(o_tx_air)) else $error("tx lead fell early");
    rx_release_a: assert property ($fell(o_rx_lead) |->
        $past(i_rx_exit) && $past(o_rx_air)) else $error("rx lead fell early");
    done_at_end_a: assert property ($rose(o_done_irq) |->
        $past(o_tx_lead, 2) && !$past(o_tx_lead) || $past(o_rx_lead, 2) && !$past(o_rx_lead))
        else $error("completion irq away from sequence end");

    tx_cal_c: cover property ($rose(o_tx_lead) && o_pll_cal);
    rx_nocal_c: cover property ($rose(o_rx_lead) && !o_pll_cal);
    done_c: cover property ($rose(o_done_irq));
endmodule // rfsc_sva

/* File: sim/rfsc_fe_model.sv */
// Front-end model: decodes the two control pins into sleep, receive or transmit.
// Assumes pin levels are sampled on the core clock.
`timescale 1ns/100ps
module rfsc_fe_model (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_tx_en,
    input  wire       i_rx_en,
    output wire [1:0] o_mode,
    output reg  [7:0] o_faults
);
    // Mode 0 is sleep, 1 receive, 2 transmit.
    assign o_mode = {i_tx_en, i_rx_en};
    // Both paths on at once would fight the switch, so it is counted.
    always @(posedge i_clk) begin
        if (i_rst) o_faults <= 8'h00;
        else if (i_tx_en && i_rx_en) o_faults <= o_faults + 8'h01;
    end
endmodule // rfsc_fe_model

/* File: sim/rf_frontend_sequence_ctrl_tb_top.sv */
// Testbench for rfsc_top: bus, sequencer, pins and interrupts.
// Assumes short lead parameters 8, 4, 6 and 3 cycles.
`timescale 1ns/100ps
module rf_frontend_sequence_ctrl_tb_top;
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'h0;
    logic        wr = 1'h0;
    logic [31:0] wdat = 32'h0;
    logic        tx_req = 1'h0;
    logic        rx_req = 1'h0;
    logic [6:0]  chan = 7'h00;
    logic        pa_off = 1'h0;
    logic        rx_exit = 1'h0;
    logic [31:0] q;
    wire  [31:0] rdata;
    wire         wait_r, tx_lead, rx_lead, tx_air, rx_air, cal;
    wire         tx_a, tx_b, rx_a, rx_b, lead_irq, done_irq;
    wire  [1:0]  fe_mode;
    wire  [7:0]  fe_faults;
    int          bad_count = 0;
    int          comparisons = 0;

    always #10 clk = ~clk;

    rfsc_top #(.TX_CAL_CYC(8), .TX_NOCAL_CYC(4), .RX_CAL_CYC(6), .RX_NOCAL_CYC(3)) i_rfsc_top (
        .i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_r), .i_tx_req(tx_req), .i_rx_req(rx_req), .i_channel(chan),
        .i_pa_off(pa_off), .i_rx_exit(rx_exit), .o_tx_lead(tx_lead), .o_rx_lead(rx_lead),
        .o_tx_air(tx_air), .o_rx_air(rx_air), .o_pll_cal(cal), .o_tx_ctrl_pin_a(tx_a),
        .o_tx_ctrl_pin_b(tx_b), .o_rx_ctrl_pin_a(rx_a), .o_rx_ctrl_pin_b(rx_b),
        .o_lead_irq(lead_irq), .o_done_irq(done_irq));
    rfsc_fe_model i_rfsc_fe_model (.i_clk(clk), .i_rst(srst), .i_tx_en(tx_a), .i_rx_en(rx_a),
        .o_mode(fe_mode), .o_faults(fe_faults));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic r, input logic [31:0] d);
        adr <= a; rd <= r; wr <= !r; wdat <= d;
        do @(posedge clk); while (wait_r !== 1'h0);
        q = rdata;
        rd <= 1'h0; wr <= 1'h0;
        @(posedge clk);
    endtask

    task automatic seq(input logic tx, input logic [6:0] ch, input int n, input logic c,
                       input logic [1:0] mode);
        int k;
        tx_req <= tx; rx_req <= !tx; chan <= ch;
        @(posedge clk);
        // A receive request during a transmit lead and an early end pulse must both be ignored.
        tx_req <= 1'h0; rx_req <= tx; pa_off <= tx; rx_exit <= !tx;
        @(posedge clk);
        rx_req <= 1'h0; pa_off <= 1'h0; rx_exit <= 1'h0;
        chk("lead", {tx_lead, rx_lead}, {tx, !tx});
        chk("cal", cal, c);
        for (k = 0; k < 100 && (tx ? tx_air : rx_air) !== 1'h1; k++) @(posedge clk);
        chk("lead time", k, n);
        chk("fe mode", fe_mode, mode);
        chk("pins b", {tx_b, rx_b}, mode);
        pa_off <= tx; rx_exit <= !tx;
        @(posedge clk);
        pa_off <= 1'h0; rx_exit <= 1'h0;
        @(posedge clk);
        chk("lead off", {tx_lead, rx_lead, tx_air, rx_air}, 4'h0);
        @(posedge clk);
    endtask

    task t_regs;
        bus(8'h0c, 1, 0); chk("det cfg", q, 32'h33);
        bus(8'h1c, 1, 0); chk("unmapped", q, 32'h0);
        bus(8'h14, 0, 32'h7); bus(8'h14, 1, 0); chk("mask", q, 32'h7);
        $display("test regs done");
    endtask

    task t_tx;
        seq(1, 7'h05, 8, 1, 2'h0);
        seq(1, 7'h05, 4, 0, 2'h0);
        bus(8'h10, 1, 0); chk("tx status", q, 32'h5);
        chk("irqs", {lead_irq, done_irq}, 2'h3);
        bus(8'h10, 0, 32'h7); bus(8'h10, 1, 0); chk("cleared", q, 32'h0);
        chk("irqs off", {lead_irq, done_irq}, 2'h0);
        $display("test tx done");
    endtask

    task t_rx;
        bus(8'h14, 0, 32'h4);
        seq(0, 7'h05, 3, 0, 2'h0);
        seq(0, 7'h09, 6, 1, 2'h0);
        bus(8'h10, 1, 0); chk("rx status", q, 32'h6);
        chk("masked irqs", {lead_irq, done_irq}, 2'h1);
        bus(8'h10, 0, 32'h7); bus(8'h14, 0, 32'h7);
        $display("test rx done");
    endtask

    task t_auto;
        bus(8'h00, 0, 32'h1); bus(8'h04, 0, 32'ha6);
        bus(8'h04, 1, 0); chk("pin af", q, 32'ha6);
        seq(1, 7'h14, 8, 1, 2'h2);
        seq(0, 7'h14, 3, 0, 2'h1);
        chk("fe faults", fe_faults, 8'h00);
        $display("test auto done");
    endtask

    task t_gpio;
        bus(8'h00, 0, 32'h0); bus(8'h08, 0, 32'hf); @(posedge clk);
        chk("gpio on", {tx_a, tx_b, rx_a, rx_b}, 4'hf);
        bus(8'h08, 0, 32'h0); @(posedge clk);
        chk("gpio off", {tx_a, tx_b, rx_a, rx_b}, 4'h0);
        $display("test gpio done");
    endtask

    task t_det;
        // Tx triggers off and rx level-high: only the rx lead and the ends are flagged.
        bus(8'h0c, 0, 32'h50); bus(8'h10, 0, 32'h7);
        seq(1, 7'h14, 4, 0, 2'h0);
        seq(0, 7'h14, 3, 0, 2'h0);
        bus(8'h10, 1, 0); chk("level status", q, 32'h6);
        bus(8'h10, 0, 32'h7); bus(8'h10, 1, 0); chk("level gone", q, 32'h0);
        // Level-low on rx sets the bit again on every cycle while the lead is low.
        bus(8'h0c, 0, 32'h60); bus(8'h10, 0, 32'h7); bus(8'h10, 1, 0);
        chk("level low", q, 32'h2);
        chk("level irq", {lead_irq, done_irq}, 2'h2);
        bus(8'h18, 1, 0); chk("state idle", q, 32'h0);
        $display("test det done");
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // The tests need well under a thousand cycles; this bound only cuts hangs.
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        close_out;
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        t_regs;
        t_tx;
        t_rx;
        t_auto;
        t_gpio;
        t_det;
        close_out;
    end
endmodule // rf_frontend_sequence_ctrl_tb_top

bind rfsc_top rfsc_sva #(.CH_W(CH_W), .TX_CAL_CYC(TX_CAL_CYC), .TX_NOCAL_CYC(TX_NOCAL_CYC),
    .RX_CAL_CYC(RX_CAL_CYC), .RX_NOCAL_CYC(RX_NOCAL_CYC)) i_rfsc_sva (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_tx_req(i_tx_req), .i_rx_req(i_rx_req),
    .i_channel(i_channel), .i_pa_off(i_pa_off), .i_rx_exit(i_rx_exit), .o_tx_lead(o_tx_lead),
    .o_rx_lead(o_rx_lead), .o_tx_air(o_tx_air), .o_rx_air(o_rx_air), .o_pll_cal(o_pll_cal),
    .o_done_irq(o_done_irq));
